/* pkg/aosr_pkg.sv */
// constants for the adc output shaping register bank
`default_nettype none
package aosr_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_FMT = 8'h0d;
    localparam logic [7:0] OFS_LANE = 8'h12;
    localparam logic [7:0] OFS_PA_CTL = 8'h13;
    localparam logic [7:0] OFS_PA_P0L = 8'h14;
    localparam logic [7:0] OFS_PA_MIX = 8'h15;
    localparam logic [7:0] OFS_PA_P1H = 8'h16;
    localparam logic [7:0] OFS_PB_CTL = 8'h18;
    localparam logic [7:0] OFS_PB_P0L = 8'h19;
    localparam logic [7:0] OFS_PB_MIX = 8'h1a;
    localparam logic [7:0] OFS_USR = 8'h1c;
    localparam logic [7:0] OFS_KEY = 8'h33;
    localparam logic [7:0] OFS_TRIG = 8'h90;
    localparam logic [7:0] OFS_TEMP = 8'h91;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [15:0] FMT_RST = 16'h2002;
    localparam logic [15:0] LANE_RST = 16'h0002;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CODING_BIT = 13;
    localparam int GAIN1_BIT = 7;
    localparam int AVG_ON_BIT = 6;
    localparam int DEPTH_LSB = 2;
    localparam int XOR_BIT = 3;
    localparam int LANE_SINGLE_BIT = 2;
    localparam int LANE_WIDE_BIT = 1;
    localparam int INC_LSB = 4;
    localparam int KIND_LSB = 2;
    localparam int PAT_ON_BIT = 1;
    localparam int USR_B_LSB = 8;
    localparam int USR_A_LSB = 0;
    localparam int GAIN3_BIT = 13;
    localparam int GAIN2_BIT = 6;
    localparam int KEY_LSB = 4;
    localparam int TRIG_BIT = 14;
    // ----------------------------------------
    // codes
    // ----------------------------------------
    localparam logic [7:0] RD_CMD = 8'hfe;
    localparam logic [1:0] KEY_OPEN = 2'h3;
    localparam logic [1:0] KIND_RAMP = 2'h2;
    localparam logic [1:0] KIND_ALT = 2'h3;
    localparam logic [4:0] LAST_BIT = 5'h17;
endpackage
`default_nettype wire

/* hw/aosr_regs.sv */
// adc output shaping register bank with serial config port
`default_nettype none
module aosr_regs (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic sclk_i,
    input wire logic cs_b_i,
    input wire logic sdi_i,
    output logic sdo_o,
    input wire logic conv_valid_i,
    input wire logic [17:0] conv_a_i,
    input wire logic [17:0] conv_b_i,
    input wire logic [9:0] temp_sensor_i,
    output logic word_valid_o,
    output logic [23:0] word_a_o,
    output logic [23:0] word_b_o,
    output logic lane_single_o,
    output logic word_24b_o,
    output logic gain_cal_on_o,
    output logic init_key_open_o
);
    // ----------------------------------------
    // state types
    // ----------------------------------------
    // link side state, clocked by the serial clock
    typedef struct packed {
        logic [4:0] cnt;    // bit position in frame
        logic [23:0] sh;    // incoming shift
        logic [23:0] frame; // last whole frame
        logic tog;          // flips once per frame
        logic [23:0] out;   // readback shift
    } aosr_link_t;

    // core side state, clocked by the device clock
    typedef struct packed {
        logic [15:0] fmt;
        logic [15:0] lane;
        logic [15:0] pa_ctl;
        logic [15:0] pa_p0l;
        logic [15:0] pa_mix;
        logic [15:0] pa_p1h;
        logic [15:0] pb_ctl;
        logic [15:0] pb_p0l;
        logic [15:0] pb_mix;
        logic [15:0] usr;
        logic [15:0] key;
        logic [15:0] trig;
        logic [15:0] temp;
        logic [2:0] fsync;     // frame toggle sync, [0] first stage
        logic [23:0] rd_word;  // address and data for readback
        logic [1:0][23:0] ramp; // ramp counters
        logic [1:0] alt;       // alternate pattern select
        logic [1:0][21:0] acc; // averaging sums
        logic [4:0] cnt;       // samples taken so far
        logic [1:0][23:0] word; // output words
        logic wv;              // word strobe
    } aosr_core_t;

    localparam aosr_core_t CORE_RST = '{
        fmt: aosr_pkg::FMT_RST,
        lane: aosr_pkg::LANE_RST,
        default: '0
    };

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic [1:0] rst_sync_q; // release synchroniser
    logic rst_n;            // synchronised reset, active low

    // release reset two clocks after the pin goes high
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    aosr_link_t ln_q;
    aosr_link_t ln_d;
    aosr_core_t co_q;
    aosr_core_t co_d;

    // ----------------------------------------
    // serial link side
    // ----------------------------------------
    // shift frames in and readback out; clock stands between frames
    always_comb begin
        ln_d = ln_q;
        if (cs_b_i) begin
            // deselected: restart framing
            ln_d.cnt = 5'h0;
        end else begin
            ln_d.sh = {ln_q.sh[22:0], sdi_i};
            if (ln_q.cnt == aosr_pkg::LAST_BIT) begin
                // whole frame: publish and flip toggle
                ln_d.cnt = 5'h0;
                ln_d.frame = {ln_q.sh[22:0], sdi_i};
                ln_d.tog = ~ln_q.tog;
            end else begin
                ln_d.cnt = ln_q.cnt + 5'h1;
            end
            if (ln_q.cnt == 5'h0) begin
                // readback word is static while frames run
                ln_d.out = co_q.rd_word;
            end else begin
                ln_d.out = {ln_q.out[22:0], 1'b0};
            end
        end
    end

    // link state register
    always_ff @(posedge sclk_i or negedge rst_n) begin
        if (!rst_n) begin
            ln_q <= '0;
        end else begin
            ln_q <= ln_d;
        end
    end
    assign sdo_o = ln_q.out[23];

    // ----------------------------------------
    // field views
    // ----------------------------------------
    logic evt;                 // one pulse per received frame
    logic [1:0][17:0] raw;     // conversion results
    logic [1:0][15:0] pctl;    // pattern control words
    logic [1:0][23:0] pat0;    // fixed word 0 per channel
    logic [1:0][23:0] pat1;    // fixed word 1 per channel
    logic [1:0][5:0] usr;      // user bits per channel
    logic [1:0] pat_on;        // pattern replaces result
    logic [1:0][1:0] kind;     // pattern kind
    logic [1:0][23:0] step;    // ramp step
    logic avg_on;
    logic xor_on;
    logic wide;                // 24-bit words
    logic [1:0] dep;
    logic [4:0] last;          // last sample index of a batch
    logic [23:0] mask;         // word width mask
    logic wev;                 // output word event

    assign evt = co_q.fsync[2] ^ co_q.fsync[1];
    assign raw[0] = conv_a_i;
    assign raw[1] = conv_b_i;
    assign pctl[0] = co_q.pa_ctl;
    assign pctl[1] = co_q.pb_ctl;
    assign pat0[0] = {co_q.pa_mix[7:0], co_q.pa_p0l};
    assign pat1[0] = {co_q.pa_p1h, co_q.pa_mix[15:8]};
    assign pat0[1] = {co_q.pb_mix[7:0], co_q.pb_p0l};
    assign pat1[1] = {16'h0, co_q.pb_mix[15:8]};
    assign usr[0] = co_q.usr[aosr_pkg::USR_A_LSB +: 6];
    assign usr[1] = co_q.usr[aosr_pkg::USR_B_LSB +: 6];

    // per channel pattern controls
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            pat_on[c] = pctl[c][aosr_pkg::PAT_ON_BIT];
            kind[c] = pctl[c][aosr_pkg::KIND_LSB +: 2];
            step[c] = {20'h0, pctl[c][aosr_pkg::INC_LSB +: 4]} + 24'h1;
        end
    end

    assign avg_on = co_q.fmt[aosr_pkg::AVG_ON_BIT];
    // depth code, batch of 2 << code
    assign dep = co_q.fmt[aosr_pkg::DEPTH_LSB +: 2];
    assign last = (5'h2 << dep) - 5'h1;
    assign xor_on = co_q.lane[aosr_pkg::XOR_BIT];
    assign wide = co_q.lane[aosr_pkg::LANE_WIDE_BIT];
    assign mask = wide ? 24'hffffff : 24'h0fffff;
    assign wev = conv_valid_i && (!avg_on || co_q.cnt == last);

    // register read multiplexer, unmapped reads give zero
    function automatic logic [15:0] rd_mux(input logic [7:0] a, input aosr_core_t s);
        case (a)
            aosr_pkg::OFS_FMT: rd_mux = s.fmt;
            aosr_pkg::OFS_LANE: rd_mux = s.lane;
            aosr_pkg::OFS_PA_CTL: rd_mux = s.pa_ctl;
            aosr_pkg::OFS_PA_P0L: rd_mux = s.pa_p0l;
            aosr_pkg::OFS_PA_MIX: rd_mux = s.pa_mix;
            aosr_pkg::OFS_PA_P1H: rd_mux = s.pa_p1h;
            aosr_pkg::OFS_PB_CTL: rd_mux = s.pb_ctl;
            aosr_pkg::OFS_PB_P0L: rd_mux = s.pb_p0l;
            aosr_pkg::OFS_PB_MIX: rd_mux = s.pb_mix;
            aosr_pkg::OFS_USR: rd_mux = s.usr;
            aosr_pkg::OFS_KEY: rd_mux = s.key;
            aosr_pkg::OFS_TRIG: rd_mux = s.trig;
            aosr_pkg::OFS_TEMP: rd_mux = s.temp;
            default: rd_mux = 16'h0;
        endcase
    endfunction

    // ----------------------------------------
    // core side
    // ----------------------------------------
    // register access, temperature capture and data shaping
    always_comb begin
        logic [21:0] sum;
        logic [17:0] res;
        logic [23:0] dw;
        logic [23:0] pw;
        sum = 22'h0;
        res = 18'h0;
        dw = 24'h0;
        pw = 24'h0;
        co_d = co_q;
        co_d.fsync = {co_q.fsync[1:0], ln_q.tog};
        co_d.wv = 1'b0;
        if (evt) begin
            if (ln_q.frame[23:16] == aosr_pkg::RD_CMD) begin
                co_d.rd_word = {ln_q.frame[7:0], rd_mux(ln_q.frame[7:0], co_q)};
            end else begin
                // plain write, unmapped addresses ignored
                case (ln_q.frame[23:16])
                    aosr_pkg::OFS_FMT: co_d.fmt = ln_q.frame[15:0];
                    aosr_pkg::OFS_LANE: co_d.lane = ln_q.frame[15:0];
                    aosr_pkg::OFS_PA_CTL: co_d.pa_ctl = ln_q.frame[15:0];
                    aosr_pkg::OFS_PA_P0L: co_d.pa_p0l = ln_q.frame[15:0];
                    aosr_pkg::OFS_PA_MIX: co_d.pa_mix = ln_q.frame[15:0];
                    aosr_pkg::OFS_PA_P1H: co_d.pa_p1h = ln_q.frame[15:0];
                    aosr_pkg::OFS_PB_CTL: co_d.pb_ctl = ln_q.frame[15:0];
                    aosr_pkg::OFS_PB_P0L: co_d.pb_p0l = ln_q.frame[15:0];
                    aosr_pkg::OFS_PB_MIX: co_d.pb_mix = ln_q.frame[15:0];
                    aosr_pkg::OFS_USR: co_d.usr = ln_q.frame[15:0];
                    aosr_pkg::OFS_KEY: co_d.key = ln_q.frame[15:0];
                    aosr_pkg::OFS_TRIG: co_d.trig = ln_q.frame[15:0];
                    aosr_pkg::OFS_TEMP: co_d.temp = ln_q.frame[15:0];
                    default: ;
                endcase
            end
        end
        if (co_d.trig[aosr_pkg::TRIG_BIT] && !co_q.trig[aosr_pkg::TRIG_BIT]) begin
            co_d.temp = {6'h0, temp_sensor_i};
        end
        // batch counter runs only when averaging
        if (conv_valid_i) begin
            co_d.cnt = (wev || !avg_on) ? 5'h0 : co_q.cnt + 5'h1;
        end
        for (int c = 0; c < 2; c++) begin
            sum = co_q.acc[c] + {4'h0, raw[c]};
            if (conv_valid_i) begin
                co_d.acc[c] = (wev || !avg_on) ? 22'h0 : sum;
            end
            res = avg_on ? 18'(sum >> ({1'b0, dep} + 3'h1)) : raw[c];
            if (co_q.fmt[aosr_pkg::CODING_BIT]) begin
                res[17] = ~res[17];
            end
            if (xor_on) begin
                res[17:1] = res[17:1] ^ {17{res[0]}};
            end
            dw = wide ? {res, usr[c]} : {4'h0, res, usr[c][5:4]};
            unique case (kind[c])
                2'h0, 2'h1: pw = pat0[c];
                aosr_pkg::KIND_RAMP: pw = co_q.ramp[c];
                aosr_pkg::KIND_ALT: pw = co_q.alt[c] ? pat1[c] : pat0[c];
            endcase
            if (wev) begin
                co_d.wv = 1'b1;
                co_d.word[c] = pat_on[c] ? (pw & mask) : dw;
                if (pat_on[c] && kind[c] == aosr_pkg::KIND_RAMP) begin
                    co_d.ramp[c] = (co_q.ramp[c] + step[c]) & mask;
                end
                if (pat_on[c] && kind[c] == aosr_pkg::KIND_ALT) begin
                    co_d.alt[c] = ~co_q.alt[c];
                end
            end
        end
    end

    // core state register
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            co_q <= CORE_RST;
        end else begin
            co_q <= co_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign word_valid_o = co_q.wv;
    assign word_a_o = co_q.word[0];
    assign word_b_o = co_q.word[1];
    assign lane_single_o = co_q.lane[aosr_pkg::LANE_SINGLE_BIT];
    assign word_24b_o = wide;
    assign gain_cal_on_o = co_q.fmt[aosr_pkg::GAIN1_BIT] | co_q.key[aosr_pkg::GAIN2_BIT]
        | co_q.key[aosr_pkg::GAIN3_BIT];
    assign init_key_open_o = co_q.key[aosr_pkg::KEY_LSB +: 2] == aosr_pkg::KEY_OPEN;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n);

    property p_coding;
        co_q.wv && $past(!pat_on[0] && !avg_on && !xor_on && wide)
            |-> co_q.word[0][23] == ($past(conv_a_i[17]) ^ $past(co_q.fmt[13]));
    endproperty
    a_coding: assert property (p_coding) else $error("coding msb wrong");

    property p_gain;
        $rose(co_q.key[aosr_pkg::GAIN2_BIT]) |-> gain_cal_on_o;
    endproperty
    a_gain: assert property (p_gain) else $error("gain enable missing");

    property p_depth;
        co_q.wv && $past(avg_on) |-> $past(co_q.cnt) == $past(last);
    endproperty
    a_depth: assert property (p_depth) else $error("batch size wrong");

    property p_xor;
        co_q.wv && $past(xor_on && !avg_on && !pat_on[0] && wide && !co_q.fmt[13])
            |-> (co_q.word[0][23:7] ^ {17{co_q.word[0][6]}}) == $past(conv_a_i[17:1]);
    endproperty
    a_xor: assert property (p_xor) else $error("xor output wrong");

    property p_ramp;
        co_q.wv && pat_on[0] && kind[0] == 2'h2 && wide && $stable(co_q.pa_ctl)
            && $past(pat_on[0] && kind[0] == 2'h2 && wide)
            |-> co_q.ramp[0] == co_q.word[0] + step[0];
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp step wrong");

    property p_fixed_a;
        co_q.wv && $past(pat_on[0] && kind[0] < 2'h2 && wide)
            |-> co_q.word[0] == $past(pat0[0]);
    endproperty
    a_fixed_a: assert property (p_fixed_a) else $error("fixed word a wrong");

    property p_fixed_b;
        co_q.wv && $past(pat_on[1] && kind[1] < 2'h2 && wide)
            |-> co_q.word[1] == $past(pat0[1]);
    endproperty
    a_fixed_b: assert property (p_fixed_b) else $error("fixed word b wrong");

    property p_user;
        co_q.wv && $past(!pat_on[0] && wide) |-> co_q.word[0][5:0] == $past(usr[0]);
    endproperty
    a_user: assert property (p_user) else $error("user bits wrong");

    property p_key;
        evt && ln_q.frame[23:16] == aosr_pkg::OFS_KEY && ln_q.frame[5:4] == 2'h3
            |=> init_key_open_o;
    endproperty
    a_key: assert property (p_key) else $error("key did not open");

    property p_temp;
        $rose(co_q.trig[aosr_pkg::TRIG_BIT]) |-> co_q.temp == {6'h0, $past(temp_sensor_i)};
    endproperty
    a_temp: assert property (p_temp) else $error("temperature not captured");

    property p_read;
        evt && ln_q.frame[23:16] == aosr_pkg::RD_CMD
            |=> co_q.rd_word[23:16] == $past(ln_q.frame[7:0]);
    endproperty
    a_read: assert property (p_read) else $error("readback address wrong");

    c_ramp: cover property (co_q.wv && pat_on[0] && kind[0] == 2'h2);
    c_read: cover property (evt && ln_q.frame[23:16] == aosr_pkg::RD_CMD);
    c_temp: cover property ($rose(co_q.trig[aosr_pkg::TRIG_BIT]));
    c_avg: cover property (co_q.wv && avg_on);
endmodule // aosr_regs
`default_nettype wire

/* testbench/aosr_host.sv */
// host model: serial config master that writes and reads the register bank
`default_nettype none
module aosr_host (
    output logic sclk_o,
    output logic cs_b_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] rx_q; // readback bits of the last frame
    // link clock stands low and select stays high between frames
    initial begin
        sclk_o = 1'b0;
        cs_b_o = 1'b1;
        sdi_o = 1'b0;
    end
    // one frame, msb first; readback is taken on falling edges
    task automatic xfer(input logic [23:0] tx);
        cs_b_o = 1'b0;
        for (int k = 23; k >= 0; k--) begin
            sdi_o = tx[k];
            #32 sclk_o = 1'b1;
            #32 sclk_o = 1'b0;
            rx_q[k] = sdo_i;
        end
        #16 cs_b_o = 1'b1;
        sdi_o = ~tx[0]; // a released line must not keep its last level
        #400; // gap well above five device clocks for the crossing
    endtask
    task automatic sel_bank();
        xfer({8'h03, 16'h0002});
    endtask
    // register write frame: address then data
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        xfer({a, d});
    endtask
    // set-up frame, then a frame that shifts out address and data
    task automatic rd(input logic [7:0] a, output logic [23:0] r);
        xfer({aosr_pkg::RD_CMD, 8'h00, a});
        xfer(24'hffffff);
        r = rx_q;
    endtask
endmodule // aosr_host
`default_nettype wire

/* testbench/aosr_regs_tb.sv */
// self-checking bench for the output shaping register bank
`default_nettype none
module aosr_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic conv_valid_i = 1'b0;
    logic [17:0] conv_a_i = 18'h0;
    logic [17:0] conv_b_i = 18'h0;
    logic [9:0] temp_sensor_i = 10'h0;
    wire sclk, cs_b, sdi, sdo, word_valid_o, lane_single_o, word_24b_o;
    wire gain_cal_on_o, init_key_open_o;
    wire [23:0] word_a_o, word_b_o;
    int err_total = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'h1ef754df; // fixed seed, repeatable run
    logic [23:0] wa, wb; // last words seen
    logic [7:0] ofs[14] = '{8'h0d, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h18, 8'h19,
        8'h1a, 8'h1c, 8'h33, 8'h90, 8'h91, 8'h20}; // last one is unmapped
    logic [15:0] kv[4] = '{16'h0040, 16'h2000, 16'h0030, 16'h0000}; // gain and key values
    // writable bits per offset; reserved bits stay at their reset value
    logic [15:0] wm[14] = '{16'h20fc, 16'h000f, 16'h00fe, 16'hffff, 16'hffff, 16'hffff,
        16'h00fe, 16'hffff, 16'hffff, 16'h3f3f, 16'h2070, 16'h4000, 16'h03ff, 16'hffff};
    always #20 clk_i = ~clk_i;
    aosr_regs dut (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .sclk_i(sclk),
        .cs_b_i(cs_b),
        .sdi_i(sdi),
        .sdo_o(sdo),
        .conv_valid_i(conv_valid_i),
        .conv_a_i(conv_a_i),
        .conv_b_i(conv_b_i),
        .temp_sensor_i(temp_sensor_i),
        .word_valid_o(word_valid_o),
        .word_a_o(word_a_o),
        .word_b_o(word_b_o),
        .lane_single_o(lane_single_o),
        .word_24b_o(word_24b_o),
        .gain_cal_on_o(gain_cal_on_o),
        .init_key_open_o(init_key_open_o)
    );
    aosr_host host (.sclk_o(sclk), .cs_b_o(cs_b), .sdi_o(sdi), .sdo_i(sdo));
    // xorshift source of random values
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected shaped word: coding, xor with lsb, user bits, width
    function automatic logic [23:0] shape(logic [17:0] v, logic tc, logic x, logic [5:0] u,
        logic w);
        if (tc) v[17] = ~v[17];
        if (x) v[17:1] = v[17:1] ^ {17{v[0]}};
        return w ? {v, u} : {4'h0, v, u[5:4]};
    endfunction
    // expected pattern word; ramp and alternate follow the previous word
    // each kind is entered once from reset: ramp starts at zero, alternate at word 0
    function automatic logic [23:0] pexp(logic [1:0] m, logic [23:0] t0, logic [23:0] t1,
        logic [3:0] inc, logic [23:0] prv, int k);
        if (m < 2'h2) return t0;
        if (k == 0) return (m == 2'h2) ? 24'h0 : t0;
        if (m == 2'h2) return prv + 24'(inc) + 24'h1;
        return (prv === t0) ? t1 : t0;
    endfunction
    // compare and count
    task automatic chk(input string n, input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", n, exp, got);
        end
    endtask
    // one conversion strobe with both results
    task automatic conv(input logic [17:0] a, input logic [17:0] b);
        @(posedge clk_i);
        conv_valid_i <= 1'b1;
        conv_a_i <= a;
        conv_b_i <= b;
        @(posedge clk_i);
        conv_valid_i <= 1'b0;
    endtask
    // wait for the word pulse, bounded, and keep both words
    task automatic getw();
        int i;
        i = 0;
        @(negedge clk_i);
        while (word_valid_o !== 1'b1 && i < 40) begin
            @(negedge clk_i);
            i++;
        end
        chk("word valid", 24'(word_valid_o), 24'h1);
        wa = word_a_o;
        wb = word_b_o;
    endtask
    // verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        #1000000;
        err_total++;
        end_of_test();
    end
    initial begin
        logic [15:0] v[14];
        logic [15:0] d16, u;
        logic [23:0] r, t0a, t1a, t0b, t1b, pa, pb;
        logic [17:0] a, b;
        logic [3:0] ia, ib;
        logic [2:0] ln;
        logic tc, x, g;
        logic [9:0] tv;
        int sum;
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        #7;
        chk("lane out", 24'({lane_single_o, word_24b_o}), 24'h1);
        host.sel_bank();
        foreach (ofs[i]) begin
            host.rd(ofs[i], r);
            chk("reset", r, {ofs[i], i == 0 ? 16'h2002 : (i == 1 ? 16'h0002 : 16'h0)});
        end
        foreach (ofs[i]) begin
            d16 = 16'(rnd()) & wm[i];
            if (i == 0) d16[1:0] = 2'h2;
            host.wr(ofs[i], d16);
            v[i] = (i == 13) ? 16'h0 : d16;
        end
        foreach (ofs[i]) begin
            host.rd(ofs[i], r);
            chk("readback", r, {ofs[i], v[i]});
        end
        // averaging may be left on by the random writes: one word per sample here
        host.wr(8'h0d, 16'h2002);
        host.wr(8'h12, 16'h0002);
        for (int m = 0; m < 4; m++) begin
            for (int i = 3; i < 9; i++) begin
                v[i] = 16'(rnd());
                if (i != 6) host.wr(ofs[i], v[i]);
            end
            ia = v[6][3:0];
            ib = v[6][7:4];
            host.wr(8'h13, {8'h0, ia, 2'(m), 2'h2});
            host.wr(8'h18, {8'h0, ib, 2'(3 - m), 2'h2});
            t0a = {v[4][7:0], v[3]};
            t1a = {v[5], v[4][15:8]};
            t0b = {v[8][7:0], v[7]};
            t1b = {16'h0, v[8][15:8]};
            for (int k = 0; k < 4; k++) begin
                conv(18'(rnd()), 18'(rnd()));
                getw();
                chk("pattern a", wa, pexp(2'(m), t0a, t1a, ia, pa, k));
                chk("pattern b", wb, pexp(2'(3 - m), t0b, t1b, ib, pb, k));
                pa = wa;
                pb = wb;
            end
        end
        host.wr(8'h13, 16'h0);
        host.wr(8'h18, 16'h0);
        // clear the key register so only the format gain bit drives the enable
        host.wr(8'h33, 16'h0);
        repeat (8) begin
            d16 = 16'(rnd());
            ln = {d16[0], d16[1], d16[0]};
            tc = d16[2];
            x = d16[3];
            g = d16[4];
            host.wr(8'h0d, {2'h0, tc, 5'h0, g, 7'h02});
            host.wr(8'h12, {12'h0, x, ln});
            u = 16'(rnd()) & 16'h3f3f;
            host.wr(8'h1c, u);
            a = 18'(rnd());
            b = 18'(rnd());
            conv(a, b);
            getw();
            chk("word a", wa, shape(a, tc, x, u[5:0], ln[1]));
            chk("word b", wb, shape(b, tc, x, u[13:8], ln[1]));
            r = 24'({lane_single_o, word_24b_o, gain_cal_on_o});
            chk("lanes", r, 24'({ln[2], ln[1], g}));
        end
        host.wr(8'h12, 16'h0002);
        for (int d = 0; d < 4; d++) begin
            host.wr(8'h0d, 16'(32'h2042 | (d << 2)));
            sum = 0;
            for (int k = 0; k < (2 << d); k++) begin
                a = 18'(rnd());
                sum += int'(a);
                conv(a, a);
            end
            getw();
            pa = shape(18'(sum >> (d + 1)), 1'b1, 1'b0, u[5:0], 1'b1);
            chk("average", wa, pa);
        end
        host.wr(8'h0d, 16'h2002);
        foreach (kv[i]) begin
            host.wr(8'h33, kv[i]);
            r = 24'({gain_cal_on_o, init_key_open_o});
            chk("gain key", r, 24'({kv[i][6] | kv[i][13], kv[i][5:4] == 2'h3}));
        end
        host.wr(8'h90, 16'h0);
        for (int j = 0; j < 3; j++) begin
            @(posedge clk_i);
            temp_sensor_i <= 10'(rnd());
            @(posedge clk_i);
            if (j != 1) tv = temp_sensor_i;
            if (j == 2) host.wr(8'h90, 16'h0);
            host.wr(8'h90, 16'h4000);
            host.rd(8'h91, r);
            chk("temperature", r, {8'h91, 6'h0, tv});
        end
        end_of_test();
    end
endmodule // aosr_regs_tb
`default_nettype wire
